// ---- design/lpm_consts.svh ----
// constants for the pll lock monitor: counts, steps, encodings and times
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_NUM_IN      6
`define LPM_NUM_PIN     4
`define LPM_NUM_LOOP    3
`define LPM_SYS_CLK_HZ  100000000
`define LPM_QUAL_TIME_S 2
`define LPM_SEC_TIME_S  1
`define LPM_MISS_LIMIT  2'h3
`define LPM_MAP_NONE    3'h0
`define LPM_SEL_NONE    3'h7
`define LPM_SOFT_STEP   24'h000e24
`define LPM_HARD_STEP   24'h000007
`define LPM_QUAL_W      28
`define LPM_SEC_W       27
`endif

// ---- design/lpm_lock_monitor.sv ----
// pll lock monitor top: signal-loss mapping, loop monitors, phase lock flags
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_lock_monitor import lpm_pkg::*; #(
  parameter int unsigned LOCK_QUAL_CYCLES = `LPM_QUAL_TIME_S * `LPM_SYS_CLK_HZ,
  parameter int unsigned SEC_CYCLES       = `LPM_SEC_TIME_S * `LPM_SYS_CLK_HZ
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // loss-of-signal pins and their mapping, 3 bits per input
  input  wire logic [3:0]  sig_loss_pin,
  input  wire logic [17:0] sig_loss_map,
  // reference activity, selection per loop (3 bits each)
  input  wire logic [5:0]  ref_edge,
  input  wire logic [2:0]  loop_slot_tick,
  input  wire logic [8:0]  loop_sel_ref,
  // phase and frequency measurements per loop
  input  wire logic [23:0] loop_phase_err,
  input  wire logic [8:0]  fine_phase_limit,
  input  wire logic [71:0] loop_freq_dev,
  input  wire logic [20:0] loop_soft_freq_bound,
  input  wire logic [47:0] loop_hard_freq_bound,
  // unlock enables per loop
  input  wire logic [2:0]  fast_miss_unlock_en,
  input  wire logic [2:0]  fine_phase_unlock_en,
  input  wire logic [2:0]  hard_freq_unlock_en,
  // phase lock timeout control
  input  wire logic [5:0]  lock_timeout_value,
  input  wire logic [1:0]  lock_timeout_scale,
  input  wire logic        phase_flag_autoclear_sel,
  input  wire logic [5:0]  flag_clear_wr,
  // per-loop status
  output logic      [2:0]  loop_fast_loss,
  output logic      [2:0]  loop_fine_loss,
  output logic      [2:0]  loop_soft_alarm,
  output logic      [2:0]  loop_hard_alarm,
  output logic      [2:0]  loop_lock_status,
  output logic      [2:0]  loop_lock_pin,
  // per-input status and qualification
  output logic      [5:0]  input_phase_lock_flag,
  output logic      [5:0]  ref_qual_loop12,
  output logic      [5:0]  ref_qual_loop3
);
  logic [3:0]            pins_s;
  logic [5:0]            los_disq;
  logic [2:0]            sel_edge;
  logic [`LPM_SEC_W-1:0] sec_cnt;
  logic                  sec_tick;
  logic [7:0]            period;
  lpm_idx_t              sel_q [2];
  logic [7:0]            pl_cnt [2];
  logic [1:0]            pl_restart;
  logic [1:0]            pl_fire;
  logic [5:0]            flag_set;
  logic [7:0]            flag_age [6];

  // bit of a six-wide vector at a selection index, zero when none
  function automatic logic pick6(input logic [5:0] v, input lpm_idx_t idx);
    pick6 = (idx < 3'h6) ? v[idx] : 1'b0;
  endfunction

  // one-hot of a selection index, empty when none
  function automatic logic [5:0] onehot6(input lpm_idx_t idx);
    onehot6 = (idx < 3'h6) ? (6'h01 << idx) : 6'h00;
  endfunction

  // pins are asynchronous to sys_clk
  lpm_sync #(.W(`LPM_NUM_PIN)) u_pin_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (sig_loss_pin),
    .q       (pins_s)
  );

  // map decode: code 0 leaves the input unqualified by any pin
  generate
    for (genvar i = 0; i < `LPM_NUM_IN; i++) begin : g_los
      lpm_idx_t map;
      assign map = sig_loss_map[3*i +: 3];
      assign los_disq[i] = (map != `LPM_MAP_NONE) && (map <= 3'h4)
                         && pick6({2'h0, pins_s}, map - 3'h1);
    end
  endgenerate

  // loop 3 ignores phase lock flags
  assign ref_qual_loop12 = ~los_disq & ~input_phase_lock_flag;
  assign ref_qual_loop3  = ~los_disq;

  // independent monitor per loop; loop 3 always honours fast loss
  generate
    for (genvar l = 0; l < `LPM_NUM_LOOP; l++) begin : g_loop
      assign sel_edge[l] = pick6(ref_edge, loop_sel_ref[3*l +: 3]);
      lpm_loop_mon #(
        .ALWAYS_FAST (l == 2),
        .QUAL_CYCLES (LOCK_QUAL_CYCLES)
      ) u_mon (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .ref_edge         (sel_edge[l]),
        .slot_tick        (loop_slot_tick[l]),
        .phase_err        (loop_phase_err[8*l +: 8]),
        .fine_phase_limit (fine_phase_limit[3*l +: 3]),
        .freq_dev         (loop_freq_dev[24*l +: 24]),
        .soft_bound       (loop_soft_freq_bound[7*l +: 7]),
        .hard_bound       (loop_hard_freq_bound[16*l +: 16]),
        .fast_en          (fast_miss_unlock_en[l]),
        .fine_en          (fine_phase_unlock_en[l]),
        .hard_en          (hard_freq_unlock_en[l]),
        .fast_loss        (loop_fast_loss[l]),
        .fine_loss        (loop_fine_loss[l]),
        .soft_alarm       (loop_soft_alarm[l]),
        .hard_alarm       (loop_hard_alarm[l]),
        .locked           (loop_lock_status[l])
      );
    end
  endgenerate

  // pin mirrors the status bit so both never disagree
  assign loop_lock_pin = loop_lock_status;

  // one-second tick shared by all timeouts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (sec_cnt == `LPM_SEC_W'(SEC_CYCLES - 1));
      if (sec_cnt == `LPM_SEC_W'(SEC_CYCLES - 1)) sec_cnt <= '0;
      else sec_cnt <= sec_cnt + 1'b1;
    end
  end

  // timeout in seconds; a zero period disables the flag
  assign period = {2'h0, lock_timeout_value} * {6'h00, lock_timeout_scale};

  // lock timeout watch for loops 1 and 2 only
  generate
    for (genvar l = 0; l < 2; l++) begin : g_pl
      lpm_idx_t sel;
      assign sel = loop_sel_ref[3*l +: 3];
      assign pl_restart[l] = loop_lock_status[l] || (sel != sel_q[l])
                           || (sel >= 3'h6) || (period == 8'h00);
      assign pl_fire[l] = !pl_restart[l] && sec_tick
                        && ((pl_cnt[l] + 8'h01) >= period);

      // a change of reference starts a fresh wait
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sel_q[l]  <= `LPM_SEL_NONE;
          pl_cnt[l] <= 8'h00;
        end else begin
          sel_q[l] <= sel;
          if (pl_restart[l] || pl_fire[l]) pl_cnt[l] <= 8'h00;
          else if (sec_tick) pl_cnt[l] <= pl_cnt[l] + 8'h01;
        end
      end
    end
  endgenerate

  assign flag_set = (pl_fire[0] ? onehot6(loop_sel_ref[2:0]) : 6'h00)
                  | (pl_fire[1] ? onehot6(loop_sel_ref[5:3]) : 6'h00);

  // per-input flag; a raise in the clearing cycle wins
  generate
    for (genvar i = 0; i < `LPM_NUM_IN; i++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          input_phase_lock_flag[i] <= 1'b0;
          flag_age[i]              <= 8'h00;
        end else if (flag_set[i]) begin
          input_phase_lock_flag[i] <= 1'b1;
          flag_age[i]              <= 8'h00;
        end else if (input_phase_lock_flag[i]) begin
          if (phase_flag_autoclear_sel) begin
            // writes are ignored while the timer owns the clear
            if (sec_tick && ((flag_age[i] + 8'h01) >= period)) begin
              input_phase_lock_flag[i] <= 1'b0;
              flag_age[i]              <= 8'h00;
            end else if (sec_tick) begin
              flag_age[i] <= flag_age[i] + 8'h01;
            end
          end else if (flag_clear_wr[i]) begin
            input_phase_lock_flag[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_LOS_DISQ: assert property (
    (sig_loss_map[2:0] == 3'h1 && $past(sig_loss_map[2:0]) == 3'h1
     && $past(sig_loss_pin[0], 2) && $past(sig_loss_pin[0], 3))
    |-> !ref_qual_loop3[0] && !ref_qual_loop12[0])
    else $error("mapped loss pin did not disqualify input");
  AST_NO_MAP: assert property (
    (sig_loss_map[2:0] == `LPM_MAP_NONE) |-> !los_disq[0])
    else $error("unmapped input disqualified by a pin");
  AST_FLAG_DISQ: assert property (
    input_phase_lock_flag[0] |-> !ref_qual_loop12[0])
    else $error("flagged input still qualified for loops 1-2");
  AST_L3_NOFLAG: assert property (
    (input_phase_lock_flag[1] && !los_disq[1]) |-> ref_qual_loop3[1])
    else $error("loop 3 qualification saw phase lock flag");
  AST_RAISE: assert property (
    (pl_fire[0] && loop_sel_ref[2:0] == 3'h0) |=> input_phase_lock_flag[0])
    else $error("timeout did not raise flag of selected input");
  AST_SET_WINS: assert property (
    (flag_set[0] && flag_clear_wr[0]) |=> input_phase_lock_flag[0])
    else $error("clear write beat a raise");
  AST_SW_CLEAR: assert property (
    (input_phase_lock_flag[0] && !phase_flag_autoclear_sel
     && flag_clear_wr[0] && !flag_set[0]) |=> !input_phase_lock_flag[0])
    else $error("write of one did not clear flag");
  AST_AUTO_HOLD: assert property (
    (input_phase_lock_flag[0] && phase_flag_autoclear_sel && !sec_tick)
    |=> input_phase_lock_flag[0])
    else $error("auto-clear flag dropped off a second boundary");
  AST_PIN_FOLLOWS: assert property (
    loop_lock_pin[2] == loop_lock_status[2])
    else $error("lock pin disagrees with status");
  COV_FLAG: cover property ($rose(input_phase_lock_flag[0]));
  COV_AUTOCLR: cover property (phase_flag_autoclear_sel ##0 $fell(input_phase_lock_flag[0]));
  COV_LOS: cover property ($rose(los_disq[3]));
endmodule

// ---- design/lpm_loop_mon.sv ----
// per-loop loss monitors and lock qualification
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_loop_mon import lpm_pkg::*; #(
  parameter bit          ALWAYS_FAST = 1'b0,
  parameter int unsigned QUAL_CYCLES = 200000000
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // selected reference activity
  input  wire logic        ref_edge,
  input  wire logic        slot_tick,
  // phase and frequency measurements
  input  wire logic [7:0]  phase_err,
  input  wire logic [2:0]  fine_phase_limit,
  input  wire logic [23:0] freq_dev,
  input  wire logic [6:0]  soft_bound,
  input  wire logic [15:0] hard_bound,
  // unlock enables
  input  wire logic        fast_en,
  input  wire logic        fine_en,
  input  wire logic        hard_en,
  // status
  output logic             fast_loss,
  output logic             fine_loss,
  output logic             soft_alarm,
  output logic             hard_alarm,
  output logic             locked
);
  lpm_lock_state_t       state;
  logic [1:0]            miss;
  logic [1:0]            next_miss;
  logic [23:0]           soft_thr;
  logic [23:0]           hard_thr;
  logic                  unlock_evt;
  logic [`LPM_QUAL_W-1:0] qual_cnt;
  logic [31:0]           quiet;

  // missed slots since the last reference edge
  always_comb begin
    next_miss = miss;
    if (ref_edge) next_miss = 2'h0;
    else if (slot_tick && miss != `LPM_MISS_LIMIT) next_miss = miss + 2'h1;
  end

  // limits scaled to 0.0002 ppm units so both steps are whole numbers
  assign soft_thr = {17'h0, soft_bound} * `LPM_SOFT_STEP;
  assign hard_thr = {8'h00, hard_bound} * `LPM_HARD_STEP;

  // monitor flags, each follows its condition one cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      miss       <= 2'h0;
      fast_loss  <= 1'b0;
      fine_loss  <= 1'b0;
      soft_alarm <= 1'b0;
      hard_alarm <= 1'b0;
    end else begin
      miss       <= next_miss;
      fast_loss  <= (next_miss == `LPM_MISS_LIMIT);
      fine_loss  <= (phase_err > {5'h00, fine_phase_limit});
      soft_alarm <= (freq_dev > soft_thr);
      hard_alarm <= (freq_dev > hard_thr);
    end
  end

  // soft alarm deliberately absent: status only
  assign unlock_evt = (fast_loss & (fast_en | ALWAYS_FAST))
                    | (fine_loss & fine_en)
                    | (hard_alarm & hard_en);

  // qualification timer, restarted by any enabled event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= LPM_IDLE;
      qual_cnt <= '0;
    end else begin
      case (state)
        LPM_IDLE: begin
          state    <= LPM_QUAL;
          qual_cnt <= '0;
        end
        LPM_QUAL: begin
          if (unlock_evt) qual_cnt <= '0;
          else if (qual_cnt == `LPM_QUAL_W'(QUAL_CYCLES - 1)) state <= LPM_LOCK;
          else qual_cnt <= qual_cnt + 1'b1;
        end
        LPM_LOCK: begin
          if (unlock_evt) begin
            state    <= LPM_QUAL;
            qual_cnt <= '0;
          end
        end
        default: state <= LPM_IDLE;
      endcase
    end
  end

  assign locked = (state == LPM_LOCK);

  // helper: cycles since the last enabled event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) quiet <= 32'h0;
    else if (unlock_evt) quiet <= 32'h0;
    else if (quiet != 32'hffffffff) quiet <= quiet + 32'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FAST_SET: assert property (
    (slot_tick && !ref_edge && miss == 2'h2) |=> fast_loss)
    else $error("fast loss not raised on third missed slot");
  AST_FAST_CLR: assert property (
    ref_edge |=> !fast_loss)
    else $error("fast loss not cleared by reference edge");
  AST_EVT_UNLOCK: assert property (
    unlock_evt |=> !locked)
    else $error("enabled event did not unlock loop");
  AST_SOFT_QUIET: assert property (
    (locked && !unlock_evt && soft_alarm) |=> locked)
    else $error("soft alarm changed lock state");
  AST_LOCK_TIME: assert property (
    $rose(locked) |-> (quiet == 32'(QUAL_CYCLES) || quiet == 32'(QUAL_CYCLES + 1)))
    else $error("lock declared at wrong quiet time");
  COV_LOCK: cover property ($rose(locked));
  COV_FAST: cover property ($rose(fast_loss));
endmodule

// ---- design/lpm_pkg.sv ----
// types shared by the pll lock monitor modules
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_IDLE = 2'b00,
    LPM_QUAL = 2'b01,
    LPM_LOCK = 2'b11
  } lpm_lock_state_t;
  typedef logic [2:0] lpm_idx_t;
endpackage

// ---- design/lpm_sync.sv ----
// two-flop synchroniser for the loss-of-signal pins
`timescale 1ns/1ps
module lpm_sync import lpm_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // asynchronous level in, synchronous level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ---- test/lpm_lock_monitor_tb.sv ----
// self-checking bench for the pll lock monitor
`timescale 1ns/1ps
module lpm_lock_monitor_tb;
  localparam int unsigned QUAL = 200;
  localparam int unsigned SEC  = 20;
  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  sig_loss_pin;
  logic [17:0] sig_loss_map;
  logic [5:0]  run;
  logic [5:0]  ref_edge;
  logic [2:0]  slot_tick;
  logic [8:0]  loop_sel_ref;
  logic [23:0] loop_phase_err;
  logic [8:0]  fine_phase_limit;
  logic [71:0] loop_freq_dev;
  logic [20:0] soft_bound;
  logic [47:0] hard_bound;
  logic [2:0]  fast_en;
  logic [2:0]  fine_en;
  logic [2:0]  hard_en;
  logic [5:0]  lock_timeout_value;
  logic [1:0]  lock_timeout_scale;
  logic        autoclear;
  logic [5:0]  flag_clear_wr;
  logic [2:0]  fast_loss;
  logic [2:0]  fine_loss;
  logic [2:0]  soft_alarm;
  logic [2:0]  hard_alarm;
  logic [2:0]  lock_status;
  logic [2:0]  lock_pin;
  logic [5:0]  flag;
  logic [5:0]  qual12;
  logic [5:0]  qual3;
  int          errors;
  int          total_checks;

  lpm_lock_monitor #(.LOCK_QUAL_CYCLES(QUAL), .SEC_CYCLES(SEC)) i_lpm_lock_monitor (
    .sys_clk(sys_clk), .rst_n(rst_n), .sig_loss_pin(sig_loss_pin),
    .sig_loss_map(sig_loss_map), .ref_edge(ref_edge), .loop_slot_tick(slot_tick),
    .loop_sel_ref(loop_sel_ref), .loop_phase_err(loop_phase_err),
    .fine_phase_limit(fine_phase_limit), .loop_freq_dev(loop_freq_dev),
    .loop_soft_freq_bound(soft_bound), .loop_hard_freq_bound(hard_bound),
    .fast_miss_unlock_en(fast_en), .fine_phase_unlock_en(fine_en),
    .hard_freq_unlock_en(hard_en), .lock_timeout_value(lock_timeout_value),
    .lock_timeout_scale(lock_timeout_scale), .phase_flag_autoclear_sel(autoclear),
    .flag_clear_wr(flag_clear_wr), .loop_fast_loss(fast_loss), .loop_fine_loss(fine_loss),
    .loop_soft_alarm(soft_alarm), .loop_hard_alarm(hard_alarm),
    .loop_lock_status(lock_status), .loop_lock_pin(lock_pin),
    .input_phase_lock_flag(flag), .ref_qual_loop12(qual12), .ref_qual_loop3(qual3));

  lpm_ref_model #(.PER(4)) i_lpm_ref_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .run(run), .ref_edge(ref_edge),
    .slot_tick(slot_tick));

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait on a lock bit (sel 0) or a phase lock flag (sel 1)
  task automatic wait_bit(input int sel, input int idx, input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      if ((sel != 0 ? flag[idx] : lock_status[idx]) === v) break;
      tick(1);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the sequence needs
  initial begin
    #100000;
    errors++;
    wrap_up();
  end

  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; errors = 0; total_checks = 0;
    sig_loss_pin = 4'h0; sig_loss_map = 18'h0; run = 6'h3f;
    loop_sel_ref = {3'h2, 3'h1, 3'h0}; loop_phase_err = 24'h0;
    fine_phase_limit = 9'h1ff;
    loop_freq_dev = 72'h0; soft_bound = {7'h7f, 7'h02, 7'h7f};
    hard_bound = {16'hffff, 16'h03e8, 16'hffff};
    fast_en = 3'h0; fine_en = 3'h0; hard_en = 3'h0; autoclear = 1'b0;
    lock_timeout_value = 6'h00; lock_timeout_scale = 2'h1; flag_clear_wr = 6'h00;
    tick(16);
    chk(qual3, 6'h3f);
    chk(6'(lock_status), 6'h0);
    rst_n = 1'b1;
    // every event disabled except loop 3 fast loss: lock comes from the timer alone
    tick(QUAL - 5); chk(6'(lock_status), 6'h0);
    tick(10); chk(6'(lock_status), 6'h7);
    chk(6'(lock_pin), 6'h7);
    // each input mapped to one pin in turn
    for (int i = 0; i < 6; i++) begin
      sig_loss_map = 18'(3'(i % 4 + 1)) << (3 * i);
      sig_loss_pin = 4'h1 << (i % 4);
      tick(3);
      chk(qual3, ~(6'h01 << i));
      chk(qual12, ~(6'h01 << i));
    end
    sig_loss_map = 18'h3ffff; sig_loss_pin = 4'hf; tick(3);
    chk(qual3, 6'h3f);
    sig_loss_map = 18'h0; sig_loss_pin = 4'h0;
    // inputs 0 and 2 fall silent, fast loss disabled on loops 1 and 2, loop 3 still honours it
    run = 6'h3a; tick(20);
    chk(6'(fast_loss), 6'h5);
    chk(6'(lock_status), 6'h3);
    run = 6'h3f; tick(6);
    chk(6'(fast_loss), 6'h0);
    fast_en = 3'h1; run = 6'h3e; tick(20);
    chk(6'(lock_status), 6'h2);
    run = 6'h3f; fast_en = 3'h0; tick(QUAL - 10);
    chk(6'(lock_status), 6'h6);
    wait_bit(0, 0, 1'b1, 30); chk(6'(lock_status), 6'h7);
    // fine phase loss on loop 1 with limit 2
    fine_phase_limit = 9'h1fa; loop_phase_err = 24'h000002; tick(3);
    chk(6'(fine_loss), 6'h0);
    loop_phase_err = 24'h000003; tick(3);
    chk(6'(fine_loss), 6'h1);
    chk(6'(lock_status), 6'h7);
    fine_en = 3'h1; tick(3); chk(6'(lock_status), 6'h6);
    loop_phase_err = 24'h0; tick(3); chk(6'(fine_loss), 6'h0);
    wait_bit(0, 0, 1'b1, QUAL + 10); chk(6'(lock_status), 6'h7);
    fine_phase_limit = 9'h1ff;
    // loop 2: soft threshold 7240, hard threshold 7000
    loop_freq_dev[47:24] = 24'h001b58; tick(3);
    chk(6'(soft_alarm), 6'h0);
    chk(6'(hard_alarm), 6'h0);
    loop_freq_dev[47:24] = 24'h001c48; tick(3);
    chk(6'(hard_alarm), 6'h2);
    chk(6'(soft_alarm), 6'h0);
    chk(6'(lock_status), 6'h7);
    loop_freq_dev[47:24] = 24'h001c49; tick(3);
    chk(6'(soft_alarm), 6'h2);
    chk(6'(lock_status), 6'h7);
    hard_en = 3'h2; tick(3); chk(6'(lock_status), 6'h5);
    loop_freq_dev[47:24] = 24'h0; tick(3);
    chk(6'(soft_alarm), 6'h0);
    chk(6'(hard_alarm), 6'h0);
    wait_bit(0, 1, 1'b1, QUAL + 10); chk(6'(lock_status), 6'h7);
    hard_en = 3'h0;
    // loop 1 kept out of lock, loop 3 starved; period of one second
    fine_en = 3'h1; loop_phase_err = 24'h0000ff; run = 6'h3b;
    lock_timeout_value = 6'h01; lock_timeout_scale = 2'h1;
    wait_bit(1, 0, 1'b1, 3 * SEC); chk(flag, 6'h01);
    chk(qual12, 6'h3e);
    chk(qual3, 6'h3f);
    flag_clear_wr = 6'h01; tick(1);
    chk(flag, 6'h00);
    flag_clear_wr = 6'h00;
    // automatic clearing ignores writes
    autoclear = 1'b1;
    wait_bit(1, 0, 1'b0, 3 * SEC);
    wait_bit(1, 0, 1'b1, 3 * SEC); chk(flag, 6'h01);
    tick(2); flag_clear_wr = 6'h01; tick(1); flag_clear_wr = 6'h00;
    chk(flag, 6'h01);
    // deselect loop 1 so no fresh raise meets the automatic clear
    loop_sel_ref = {3'h2, 3'h1, 3'h7};
    wait_bit(1, 0, 1'b0, 3 * SEC); chk(flag, 6'h00);
    tick(5);
    wrap_up();
  end
endmodule

// ---- test/lpm_ref_model.sv ----
// reference source model: active edges per input and expected-cycle slots per loop
`timescale 1ns/1ps
module lpm_ref_model import lpm_pkg::*; #(
  parameter int PER = 4
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // which references are running
  input  wire logic [5:0] run,
  // activity towards the monitor
  output logic      [5:0] ref_edge,
  output logic      [2:0] slot_tick
);
  logic [7:0] phase_cnt;

  // free-running phase of the nominal reference period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= 8'h00;
    end else if (phase_cnt == 8'(PER - 1)) begin
      phase_cnt <= 8'h00;
    end else begin
      phase_cnt <= phase_cnt + 8'h01;
    end
  end

  // a stopped source loses its edges while slots keep coming, so misses pile up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_edge  <= 6'h00;
      slot_tick <= 3'h0;
    end else begin
      ref_edge  <= (phase_cnt == 8'h00) ? run : 6'h00;
      slot_tick <= (phase_cnt == 8'h00) ? 3'h7 : 3'h0;
    end
  end
endmodule
